// >>> rtl/ppm_pkg.sv
// Purpose: shared constants and carrier types of the pin integration unit
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: register indices are word indices; byte address is four times the index
package ppm_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W = 10;
   localparam int PA_W = 8;
   localparam int PE_W = 2;
   localparam int PD_W = 8;

   // register indices
   localparam logic [IDX_W-1:0] IDX_PORT_A_DATA = 10'h000;
   localparam logic [IDX_W-1:0] IDX_PORT_E_DATA = 10'h001;
   localparam logic [IDX_W-1:0] IDX_PORT_A_DIR = 10'h002;
   localparam logic [IDX_W-1:0] IDX_PORT_E_DIR = 10'h003;
   localparam logic [IDX_W-1:0] IDX_PULL_CONTROL = 10'h00C;
   localparam logic [IDX_W-1:0] IDX_DRIVE_REDUCE = 10'h00D;
   localparam logic [IDX_W-1:0] IDX_DIE_CLK_DRIVE = 10'h00E;
   localparam logic [IDX_W-1:0] IDX_PORT_A_PIN_IN = 10'h120;
   localparam logic [IDX_W-1:0] IDX_PORT_E_PIN_IN = 10'h121;

   // field positions
   localparam int PULL_DIE_BIT = 1;
   localparam int PULL_KEEP_BIT = 6;
   localparam int DIE_CLK_REDUCE_BIT = 0;
   localparam int SS_BIT = 3;

   // reset values
   localparam logic [PA_W-1:0] RST_PORT_A = 8'h00;
   localparam logic [PE_W-1:0] RST_PORT_E = 2'h0;
   localparam logic [7:0] RST_PULL = 8'h02;
   localparam logic [PD_W-1:0] RST_DRIVE = 8'h00;
   localparam logic RST_DIE_CLK_DRIVE = 1'b0;

   // serial interface pin requests, bit order ss, sck, mosi, miso
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } ppm_spi_pins_t;

   // two-signal view (out and oe) of a bidirectional pin group
   typedef struct packed {
      logic [PD_W-1:0] out;
      logic [PD_W-1:0] oe;
   } ppm_die_pins_t;
endpackage

// >>> rtl/ppm_sync.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs arrive from outside the clock domain
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ppm_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/ppm_top.sv
// Purpose: pin integration unit: serial, oscillator and die link pin muxing, GPIO ports A and E
// Assumes: APB slave with zero wait states, all pin inputs asynchronous
// Notes: pin outputs are registered, so a function request reaches the pin one cycle later
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ppm_top #(
   parameter int PA_W = 8,
   parameter int PE_W = 2,
   parameter int PD_W = 8
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ppm_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // serial interface side
   input wire logic SPI_EN,
   input wire logic SPI_MASTER,
   input wire logic SPI_SS_OUT_EN,
   input wire ppm_pkg::ppm_spi_pins_t SPI_PINS,
   output logic [3:0] SPI_IN,
   // oscillator side
   input wire logic OSC_EN,
   // port A pins
   input wire logic [PA_W-1:0] PA_IN,
   output logic [PA_W-1:0] PA_OUT,
   output logic [PA_W-1:0] PA_OE,
   // port E pins
   input wire logic [PE_W-1:0] PE_IN,
   output logic [PE_W-1:0] PE_OUT,
   output logic [PE_W-1:0] PE_OE,
   // die link side
   input wire logic DIE_CLK,
   input wire logic DIE_WIDE,
   input wire ppm_pkg::ppm_die_pins_t DIE_DATA,
   output logic DIE_IRQ,
   output logic [PD_W-1:0] DIE_DATA_IN,
   // port C pins
   output logic DIE_CLK_PIN_OUT,
   output logic DIE_CLK_PIN_OE,
   output logic DIE_CLK_REDUCED,
   input wire logic DIE_IRQ_PIN_IN,
   output logic DIE_IRQ_PULLDOWN,
   // port D pins
   input wire logic [PD_W-1:0] DIE_DATA_PIN_IN,
   output logic [PD_W-1:0] DIE_DATA_PIN_OUT,
   output logic [PD_W-1:0] DIE_DATA_PIN_OE,
   output logic [PD_W-1:0] DIE_DATA_PULLDOWN,
   output logic [PD_W-1:0] DIE_DATA_REDUCED
);
   localparam int SYNC_W = PA_W + PE_W + PD_W + 1;

   logic [PA_W-1:0] port_a_data;
   logic [PA_W-1:0] port_a_dir;
   logic [PE_W-1:0] port_e_data;
   logic [PE_W-1:0] port_e_dir;
   logic [7:0] pull_control;
   logic [PD_W-1:0] drive_reduce;
   logic die_clk_drive;
   logic [PA_W-1:0] a_sync;
   logic [PE_W-1:0] e_sync;
   logic [PD_W-1:0] d_sync;
   logic irq_sync;
   logic [ppm_pkg::IDX_W-1:0] idx;
   logic setup_rd;
   logic access_wr;
   logic [31:0] next_rdata;
   logic [PA_W-1:0] next_a_out;
   logic [PA_W-1:0] next_a_oe;
   logic [PE_W-1:0] next_e_oe;
   logic [PD_W-1:0] next_d_oe;
   logic pull_on;

   // every pin level is synchronised once, then shared by reads and users
   ppm_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(CLK),
      .rst_n(RST_N),
      .d({DIE_IRQ_PIN_IN, DIE_DATA_PIN_IN, PE_IN, PA_IN}),
      .q({irq_sync, d_sync, e_sync, a_sync})
   );

   assign idx = PADDR[ppm_pkg::IDX_W+1:2];
   assign setup_rd = PSEL && !PENABLE && !PWRITE;
   assign access_wr = PSEL && PENABLE && PWRITE;
   // zero wait states; nothing is ever refused
   assign PREADY = PSEL && PENABLE;
   assign PSLVERR = 1'b0;

   // register writes; unmapped indices fall through untouched
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         port_a_data <= ppm_pkg::RST_PORT_A;
         port_a_dir <= ppm_pkg::RST_PORT_A;
         port_e_data <= ppm_pkg::RST_PORT_E;
         port_e_dir <= ppm_pkg::RST_PORT_E;
         pull_control <= ppm_pkg::RST_PULL;
         drive_reduce <= ppm_pkg::RST_DRIVE;
         die_clk_drive <= ppm_pkg::RST_DIE_CLK_DRIVE;
      end else if (access_wr) begin
         unique case (idx)
            ppm_pkg::IDX_PORT_A_DATA: port_a_data <= PWDATA[PA_W-1:0];
            ppm_pkg::IDX_PORT_E_DATA: port_e_data <= PWDATA[PE_W-1:0];
            ppm_pkg::IDX_PORT_A_DIR: port_a_dir <= PWDATA[PA_W-1:0];
            ppm_pkg::IDX_PORT_E_DIR: port_e_dir <= PWDATA[PE_W-1:0];
            ppm_pkg::IDX_PULL_CONTROL: begin
               pull_control <= '0;
               pull_control[ppm_pkg::PULL_DIE_BIT] <= PWDATA[ppm_pkg::PULL_DIE_BIT];
               pull_control[ppm_pkg::PULL_KEEP_BIT] <= PWDATA[ppm_pkg::PULL_KEEP_BIT];
            end
            ppm_pkg::IDX_DRIVE_REDUCE: drive_reduce <= PWDATA[PD_W-1:0];
            ppm_pkg::IDX_DIE_CLK_DRIVE: die_clk_drive <= PWDATA[ppm_pkg::DIE_CLK_REDUCE_BIT];
            default: ;
         endcase
      end
   end

   // read mux; the word is caught in the setup cycle so PRDATA is a flop
   always_comb begin
      next_rdata = '0;
      unique case (idx)
         ppm_pkg::IDX_PORT_A_DATA: next_rdata[PA_W-1:0] = (port_a_dir & port_a_data) | (~port_a_dir & a_sync);
         ppm_pkg::IDX_PORT_E_DATA: next_rdata[PE_W-1:0] = (port_e_dir & port_e_data) | (~port_e_dir & e_sync);
         ppm_pkg::IDX_PORT_A_DIR: next_rdata[PA_W-1:0] = port_a_dir;
         ppm_pkg::IDX_PORT_E_DIR: next_rdata[PE_W-1:0] = port_e_dir;
         ppm_pkg::IDX_PULL_CONTROL: next_rdata[7:0] = pull_control;
         ppm_pkg::IDX_DRIVE_REDUCE: next_rdata[PD_W-1:0] = drive_reduce;
         ppm_pkg::IDX_DIE_CLK_DRIVE: next_rdata[ppm_pkg::DIE_CLK_REDUCE_BIT] = die_clk_drive;
         ppm_pkg::IDX_PORT_A_PIN_IN: next_rdata[PA_W-1:0] = a_sync;
         ppm_pkg::IDX_PORT_E_PIN_IN: next_rdata[PE_W-1:0] = e_sync;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= '0;
      end else if (setup_rd) begin
         PRDATA <= next_rdata;
      end
   end

   // port A: serial function above GPIO on bits 3..0, GPIO alone above
   genvar g;
   generate
      for (g = 0; g < PA_W; g++) begin : g_port_a
         if (g < 4) begin : g_spi
            always_comb begin
               if (SPI_EN && (g != ppm_pkg::SS_BIT || (SPI_MASTER && SPI_SS_OUT_EN))) begin
                  next_a_out[g] = SPI_PINS.out[g];
                  next_a_oe[g] = SPI_PINS.oe[g];
               end else if (SPI_EN) begin
                  next_a_out[g] = 1'b0;
                  next_a_oe[g] = 1'b0;
               end else begin
                  next_a_out[g] = port_a_data[g];
                  next_a_oe[g] = port_a_dir[g];
               end
            end
         end else begin : g_gpio
            always_comb begin
               next_a_out[g] = port_a_data[g];
               next_a_oe[g] = port_a_dir[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PA_OUT <= '0;
         PA_OE <= '0;
      end else begin
         PA_OUT <= next_a_out;
         PA_OE <= next_a_oe;
      end
   end

   // the serial interface samples inputs through the same synchroniser
   assign SPI_IN = a_sync[3:0];

   // port E: the oscillator is analog, so taking the pins means releasing the driver
   assign next_e_oe = OSC_EN ? '0 : port_e_dir;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PE_OUT <= '0;
         PE_OE <= '0;
      end else begin
         PE_OUT <= OSC_EN ? '0 : port_e_data;
         PE_OE <= next_e_oe;
      end
   end

   // port C: clock out driven whenever out of reset, irq pin always an input
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         DIE_CLK_PIN_OUT <= 1'b0;
         DIE_CLK_PIN_OE <= 1'b0;
         DIE_CLK_REDUCED <= 1'b0;
         DIE_IRQ_PULLDOWN <= 1'b0;
      end else begin
         DIE_CLK_PIN_OUT <= DIE_CLK;
         DIE_CLK_PIN_OE <= 1'b1;
         DIE_CLK_REDUCED <= die_clk_drive;
         DIE_IRQ_PULLDOWN <= pull_on;
      end
   end

   assign DIE_IRQ = irq_sync;
   assign pull_on = pull_control[ppm_pkg::PULL_DIE_BIT];

   // port D: in narrow mode the upper nibble is never driven
   always_comb begin
      next_d_oe = DIE_DATA.oe;
      if (!DIE_WIDE) begin
         next_d_oe[PD_W-1:PD_W/2] = '0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         DIE_DATA_PIN_OUT <= '0;
         DIE_DATA_PIN_OE <= '0;
         DIE_DATA_PULLDOWN <= '0;
         DIE_DATA_REDUCED <= '0;
      end else begin
         DIE_DATA_PIN_OUT <= DIE_DATA.out;
         DIE_DATA_PIN_OE <= next_d_oe;
         // a pull-down would fight the driver, so it only sits on inputs
         DIE_DATA_PULLDOWN <= pull_on ? ~next_d_oe : '0;
         DIE_DATA_REDUCED <= drive_reduce;
      end
   end

   assign DIE_DATA_IN = d_sync;

   // checks
   a_gpio_hi_drive: assert property (@(posedge CLK) disable iff (!RST_N)
      1 |=> PA_OE[7:4] == $past(port_a_dir[7:4]) && PA_OUT[7:4] == $past(port_a_data[7:4]))
      else $error("port A upper GPIO pins do not follow data and direction");

   a_spi_owns_sck: assert property (@(posedge CLK) disable iff (!RST_N)
      SPI_EN |=> PA_OUT[2] == $past(SPI_PINS.out[2]) && PA_OE[2] == $past(SPI_PINS.oe[2]))
      else $error("serial clock pin not handed to the serial interface");

   a_ss_slave_in: assert property (@(posedge CLK) disable iff (!RST_N)
      SPI_EN && !(SPI_MASTER && SPI_SS_OUT_EN) |=> !PA_OE[3])
      else $error("slave select driven outside master output mode");

   a_gpio_fallback: assert property (@(posedge CLK) disable iff (!RST_N)
      !SPI_EN ##1 !SPI_EN |-> PA_OE[3:0] == $past(port_a_dir[3:0]))
      else $error("port A low pins do not fall back to GPIO");

   a_osc_release: assert property (@(posedge CLK) disable iff (!RST_N)
      OSC_EN |=> PE_OE == '0)
      else $error("port E driven while oscillator owns it");

   a_reset_inputs: assert property (@(posedge CLK)
      $rose(RST_N) |-> PA_OE == '0 && PE_OE == '0 && port_a_dir == '0)
      else $error("ports not inputs after reset");

   a_narrow_nibble: assert property (@(posedge CLK) disable iff (!RST_N)
      !DIE_WIDE |=> DIE_DATA_PIN_OE[PD_W-1:PD_W/2] == '0)
      else $error("upper data pins driven in narrow mode");

   a_pulldown_in: assert property (@(posedge CLK) disable iff (!RST_N)
      pull_on |=> (DIE_DATA_PULLDOWN & DIE_DATA_PIN_OE) == '0 && (DIE_DATA_PULLDOWN | DIE_DATA_PIN_OE) == '1)
      else $error("pull-down not matched to input pins");

   a_reduce_follow: assert property (@(posedge CLK) disable iff (!RST_N)
      access_wr && idx == ppm_pkg::IDX_DRIVE_REDUCE |=> ##1 DIE_DATA_REDUCED == $past(PWDATA[PD_W-1:0], 2))
      else $error("reduced drive does not follow its register");

   a_pin_input_rd: assert property (@(posedge CLK) disable iff (!RST_N)
      setup_rd && idx == ppm_pkg::IDX_PORT_A_PIN_IN |=> PRDATA == {24'h000000, $past(a_sync)})
      else $error("port A pin input read wrong");

   a_pe_upper_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      setup_rd && idx == ppm_pkg::IDX_PORT_E_DATA |=> PRDATA[31:PE_W] == '0)
      else $error("port E upper bits not zero");

   a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      setup_rd && idx == 10'h004 |=> PRDATA == 32'h00000000)
      else $error("reserved location reads non-zero");

   a_die_clk_fwd: assert property (@(posedge CLK) disable iff (!RST_N)
      1 |=> DIE_CLK_PIN_OUT == $past(DIE_CLK) && DIE_CLK_PIN_OE)
      else $error("die clock not forwarded to its pin");

   a_irq_pulldown: assert property (@(posedge CLK) disable iff (!RST_N)
      1 |=> DIE_IRQ_PULLDOWN == $past(pull_on))
      else $error("irq pin pull-down does not follow its enable");

   a_dir_write: assert property (@(posedge CLK) disable iff (!RST_N)
      access_wr && idx == ppm_pkg::IDX_PORT_A_DIR |=> port_a_dir == $past(PWDATA[PA_W-1:0]))
      else $error("port A direction write not stored");

   a_e_gpio_drive: assert property (@(posedge CLK) disable iff (!RST_N)
      !OSC_EN |=> PE_OUT == $past(port_e_data) && PE_OE == $past(port_e_dir))
      else $error("port E GPIO pins do not follow data and direction");

   a_data_rd_out: assert property (@(posedge CLK) disable iff (!RST_N)
      setup_rd && idx == ppm_pkg::IDX_PORT_A_DATA |=> (PRDATA[PA_W-1:0] & $past(port_a_dir)) == $past(port_a_data & port_a_dir))
      else $error("port A data read does not return stored bits of outputs");

   c_spi_master: cover property (@(posedge CLK) disable iff (!RST_N)
      SPI_EN && SPI_MASTER && SPI_SS_OUT_EN ##1 PA_OE[3]);
   c_osc_taken: cover property (@(posedge CLK) disable iff (!RST_N)
      OSC_EN && port_e_dir != '0);
   c_gpio_write_read: cover property (@(posedge CLK) disable iff (!RST_N)
      access_wr && idx == ppm_pkg::IDX_PORT_A_DATA ##[1:20] setup_rd && idx == ppm_pkg::IDX_PORT_A_DATA);
   c_narrow_die: cover property (@(posedge CLK) disable iff (!RST_N)
      !DIE_WIDE && DIE_DATA.oe != '0);
   c_spi_slave: cover property (@(posedge CLK) disable iff (!RST_N)
      SPI_EN && !SPI_MASTER ##1 !PA_OE[3]);
endmodule
`default_nettype wire

// >>> testbench/port_pin_mux_gpio_tb_top.sv
// Purpose: self-checking bench for the pin integration unit
// Assumes: zero wait APB slave, registered pin outputs, two-flop input sync
// Notes: waits of a few cycles cover the register and sync delays on the pins
`timescale 1ns/1ps
`default_nettype none
module port_pin_mux_gpio_tb_top;
   localparam int LIMIT = 5000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic spi_en = 1'b0;
   logic spi_master = 1'b0;
   logic spi_ss_out_en = 1'b0;
   logic osc_en = 1'b0;
   logic die_clk = 1'b0;
   logic die_wide = 1'b1;
   logic die_irq_pin_in = 1'b0;
   logic [7:0] pa_ext = 8'h3C;
   logic [1:0] pe_ext = 2'h2;
   logic [7:0] dd_ext = 8'h96;
   ppm_pkg::ppm_spi_pins_t spi_pins = '0;
   ppm_pkg::ppm_die_pins_t die_data = '0;
   logic pready, pslverr, die_irq, die_clk_pin_out, die_clk_pin_oe, die_clk_reduced, die_irq_pulldown;
   logic [31:0] prdata;
   logic [3:0] spi_in;
   logic [7:0] pa_in, pa_out, pa_oe, dd_in, die_data_in, dd_out, dd_oe, dd_pd, dd_red;
   logic [1:0] pe_in, pe_out, pe_oe;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   ppm_top ppm_top_inst (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .SPI_EN(spi_en), .SPI_MASTER(spi_master), .SPI_SS_OUT_EN(spi_ss_out_en), .SPI_PINS(spi_pins),
      .SPI_IN(spi_in), .OSC_EN(osc_en), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PE_IN(pe_in),
      .PE_OUT(pe_out), .PE_OE(pe_oe), .DIE_CLK(die_clk), .DIE_WIDE(die_wide), .DIE_DATA(die_data),
      .DIE_IRQ(die_irq), .DIE_DATA_IN(die_data_in), .DIE_CLK_PIN_OUT(die_clk_pin_out),
      .DIE_CLK_PIN_OE(die_clk_pin_oe), .DIE_CLK_REDUCED(die_clk_reduced), .DIE_IRQ_PIN_IN(die_irq_pin_in),
      .DIE_IRQ_PULLDOWN(die_irq_pulldown), .DIE_DATA_PIN_IN(dd_in), .DIE_DATA_PIN_OUT(dd_out),
      .DIE_DATA_PIN_OE(dd_oe), .DIE_DATA_PULLDOWN(dd_pd), .DIE_DATA_REDUCED(dd_red));
   ppm_pin_model #(.W(8)) pa_pins_inst (.dev_out(pa_out), .dev_oe(pa_oe), .ext(pa_ext), .pin(pa_in));
   ppm_pin_model #(.W(2)) pe_pins_inst (.dev_out(pe_out), .dev_oe(pe_oe), .ext(pe_ext), .pin(pe_in));
   ppm_pin_model #(.W(8)) dd_pins_inst (.dev_out(dd_out), .dev_oe(dd_oe), .ext(dd_ext), .pin(dd_in));

   task automatic complete_run();
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wdata,
                      output logic [31:0] rdata);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wdata;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] wdata);
      logic [31:0] dummy;
      apb(1'b1, idx, wdata, dummy);
   endtask

   task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] got;
      apb(1'b0, idx, 32'h0, got);
      chk(what, exp, got);
   endtask

   // outputs are registered and inputs pass two flops, so four edges cover both
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk("pa_oe reset", 32'h0, {24'h0, pa_oe});
      chk("pe_oe reset", 32'h0, {30'h0, pe_oe});
      chk("die clk oe", 32'h1, {31'h0, die_clk_pin_oe});
      chk("irq pulldown reset", 32'h1, {31'h0, die_irq_pulldown});
      rd_chk("port_a_direction reset", ppm_pkg::IDX_PORT_A_DIR, 32'h0);
      rd_chk("port_e_direction reset", ppm_pkg::IDX_PORT_E_DIR, 32'h0);
      rd_chk("pull_control reset", ppm_pkg::IDX_PULL_CONTROL, 32'h02);
      rd_chk("drive_reduce reset", ppm_pkg::IDX_DRIVE_REDUCE, 32'h0);
      rd_chk("port_a_data inputs", ppm_pkg::IDX_PORT_A_DATA, 32'h3C);
      wr(ppm_pkg::IDX_PORT_A_DATA, 32'hA5);
      wr(ppm_pkg::IDX_PORT_A_DIR, 32'h0F);
      settle();
      chk("pa_oe gpio", 32'h0F, {24'h0, pa_oe});
      chk("pa_out gpio low", 32'h5, {28'h0, pa_out[3:0]});
      rd_chk("port_a_data mixed", ppm_pkg::IDX_PORT_A_DATA, 32'h35);
      rd_chk("port_a_pin_input", ppm_pkg::IDX_PORT_A_PIN_IN, 32'h35);
      spi_en <= 1'b1;
      spi_master <= 1'b1;
      spi_ss_out_en <= 1'b1;
      spi_pins <= '{out: 4'hA, oe: 4'hF};
      settle();
      chk("pa_out spi", 32'hA, {28'h0, pa_out[3:0]});
      chk("pa_oe spi master", 32'h0F, {24'h0, pa_oe});
      @(posedge clk);
      spi_master <= 1'b0;
      settle();
      chk("pa_oe spi slave", 32'h07, {24'h0, pa_oe});
      chk("spi_in", 32'hA, {28'h0, spi_in});
      @(posedge clk);
      spi_en <= 1'b0;
      settle();
      chk("pa_oe back to gpio", 32'h0F, {24'h0, pa_oe});
      chk("pa_out back to gpio", 32'h5, {28'h0, pa_out[3:0]});
      wr(ppm_pkg::IDX_PORT_E_DIR, 32'hFF);
      wr(ppm_pkg::IDX_PORT_E_DATA, 32'hFF);
      rd_chk("port_e_direction", ppm_pkg::IDX_PORT_E_DIR, 32'h03);
      rd_chk("port_e_data", ppm_pkg::IDX_PORT_E_DATA, 32'h03);
      settle();
      chk("pe_oe gpio", 32'h3, {30'h0, pe_oe});
      chk("pe_out gpio", 32'h3, {30'h0, pe_out});
      @(posedge clk);
      osc_en <= 1'b1;
      settle();
      chk("pe_oe oscillator", 32'h0, {30'h0, pe_oe});
      rd_chk("port_e_pin_input", ppm_pkg::IDX_PORT_E_PIN_IN, 32'h2);
      wr(10'h004, 32'hFF);
      chk("pslverr", 32'h0, {31'h0, pslverr});
      rd_chk("reserved", 10'h004, 32'h0);
      rd_chk("reserved high", 10'h17F, 32'h0);
      die_clk <= 1'b1;
      die_wide <= 1'b0;
      die_irq_pin_in <= 1'b1;
      die_data <= '{out: 8'hFF, oe: 8'hFF};
      settle();
      chk("die clk out", 32'h1, {31'h0, die_clk_pin_out});
      chk("die irq", 32'h1, {31'h0, die_irq});
      chk("die oe narrow", 32'h0F, {24'h0, dd_oe});
      chk("die pulldown narrow", 32'hF0, {24'h0, dd_pd});
      chk("die data out", 32'hFF, {24'h0, dd_out});
      @(posedge clk);
      die_wide <= 1'b1;
      settle();
      chk("die oe wide", 32'hFF, {24'h0, dd_oe});
      chk("die pulldown wide", 32'h00, {24'h0, dd_pd});
      @(posedge clk);
      die_data <= '{out: 8'h00, oe: 8'h00};
      settle();
      chk("die data in", 32'h96, {24'h0, die_data_in});
      chk("die pulldown inputs", 32'hFF, {24'h0, dd_pd});
      wr(ppm_pkg::IDX_PULL_CONTROL, 32'h00);
      wr(ppm_pkg::IDX_DRIVE_REDUCE, 32'h5A);
      wr(ppm_pkg::IDX_DIE_CLK_DRIVE, 32'h01);
      settle();
      chk("die pulldown off", 32'h00, {24'h0, dd_pd});
      chk("irq pulldown off", 32'h0, {31'h0, die_irq_pulldown});
      chk("data reduced", 32'h5A, {24'h0, dd_red});
      chk("clk reduced", 32'h1, {31'h0, die_clk_reduced});
      complete_run();
   end
endmodule
`default_nettype wire

// >>> testbench/ppm_pin_model.sv
// Purpose: far-side pin model: each pin carries the device drive, else the external level
// Assumes: one driver per pin, device output enable high while driving
// Notes: undriven pins take the level the bench gives, never a held copy of the last drive
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_model #(
   parameter int W = 8
) (
   // device side
   input wire logic [W-1:0] dev_out,
   input wire logic [W-1:0] dev_oe,
   // external side
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin
);
   // bitwise resolve so a half-driven port still shows the outside world on the released bits
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin[i] = dev_oe[i] ? dev_out[i] : ext[i];
      end
   end
endmodule
`default_nettype wire
